// ===== core/frame_start_timer.sv
// Purpose: paces frame starts once the bus is operational
// Assumes: run is a registered level on core_clk
// Notes:   first pulse comes PERIOD-1 cycles after run rises, in the PERIOD-th cycle of run
`timescale 1ns/1ps
module frame_start_timer
#(
	parameter int unsigned PERIOD = 250000
)
(
	input  wire logic core_clk,
	input  wire logic reset_n,
	input  wire logic run,
	output logic      frame_pulse
);
	// ********************************
	// frame counter
	// ********************************
	logic [31:0] count_ff;  // cycles into current frame
	logic [31:0] nxt_count; // next count
	wire         at_end = (count_ff == 32'(PERIOD - 1)); // last cycle

	// restart on every run drop, so each entry waits a full period
	assign nxt_count   = (!run || at_end) ? 32'h0000_0000 : count_ff + 32'h0000_0001;
	assign frame_pulse = run && at_end;

	// counter register
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			count_ff <= 32'h0000_0000;
		else
			count_ff <= nxt_count;
	end
endmodule : frame_start_timer

// ===== core/host_mode_control_bank.sv
// Purpose: mode control register, functional state, wake and routing
// Assumes: APB slave, zero wait states, one clock core_clk
// Notes:   rules of operation listed below
`timescale 1ns/1ps
`include "host_mode_control_params.svh"
module host_mode_control_bank
#(
	parameter int unsigned SOF_DELAY_CYCLES = `SOF_DELAY_CYCLES
)
(
	input  wire logic                            core_clk,
	input  wire logic                            reset_n,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire host_mode_control_pkg::apb_addr_t paddr,
	input  wire host_mode_control_pkg::apb_word_t pwdata,
	output host_mode_control_pkg::apb_word_t      prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	input  wire logic                            downstream_resume,
	output logic                                 frame_start,
	output logic                                 remote_wake,
	output logic                                 irq_normal,
	output logic                                 irq_smi,
	output logic                                 port_reset_drive,
	output logic                                 root_hub_reset
);
	import host_mode_control_pkg::*;
	// every assertion below runs on core_clk, off during reset
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);

	// ********************************
	// decode helpers
	// ********************************
	// address match on one word
	function automatic logic hit(input apb_addr_t addr, input apb_addr_t off);
		hit = (addr == off);
	endfunction : hit

	// ********************************
	// bus decode
	// ********************************
	wire setup_rd  = psel && !penable && !pwrite;      // read setup cycle
	wire access_wr = psel && penable && pwrite;        // write access cycle
	wire hit_ctrl  = hit(paddr, `OFF_MODE_CONTROL);    // control word
	wire hit_cmd   = hit(paddr, `OFF_RESET_COMMAND);   // reset command
	wire hit_flags = hit(paddr, `OFF_EVENT_FLAGS);     // event flags
	wire hit_mask  = hit(paddr, `OFF_EVENT_MASK);      // event mask
	wire hit_any   = hit_ctrl || hit_cmd || hit_flags || hit_mask;
	wire ctrl_wr   = access_wr && hit_ctrl;            // control write
	wire flags_wr  = access_wr && hit_flags;           // flag clear write
	wire mask_wr   = access_wr && hit_mask;            // mask write
	// software reset request, one cycle
	wire soft_reset = access_wr && hit_cmd && pwdata[`CMD_SOFT_RESET_BIT];

	// zero wait states; data is registered in the setup cycle
	assign pready  = 1'b1;
	// unmapped words answer with an error in the access cycle
	assign pslverr = psel && penable && !hit_any;

	// ********************************
	// control register state
	// ********************************
	fs_code_t    state_ff;      // functional state
	logic [5:0]  list_ctrl_ff;  // list enables and ratio, plain storage
	logic        wake_en_ff;    // remote_wake_enable
	logic        wake_conn_ff;  // remote_wake_connected
	logic        route_ff;      // interrupt_routing_select
	event_bits_t flags_ff;      // host_event_flags
	event_bits_t mask_ff;       // event mask
	fs_code_t    nxt_state;     // next functional state
	logic [5:0]  nxt_list_ctrl; // next list fields
	logic        nxt_wake_en;   // next wake enable
	logic        nxt_wake_conn; // next connected bit
	logic        nxt_route;     // next routing bit
	event_bits_t nxt_flags;     // next flags
	event_bits_t nxt_mask;      // next mask

	// ********************************
	// downstream resume synchroniser
	// ********************************
	logic res_s1_ff;   // first stage, read only by second
	logic res_s2_ff;   // second stage
	logic res_s3_ff;   // third stage
	logic res_lvl_ff;  // accepted level
	// a change counts once stages two and three agree
	wire  res_agree = (res_s2_ff == res_s3_ff);
	wire  resume_evt = res_agree && res_s3_ff && !res_lvl_ff;

	// three-stage capture of the pin
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			res_s1_ff  <= 1'b0;
			res_s2_ff  <= 1'b0;
			res_s3_ff  <= 1'b0;
			res_lvl_ff <= 1'b0;
		end
		else
		begin
			res_s1_ff <= downstream_resume;
			res_s2_ff <= res_s1_ff;
			res_s3_ff <= res_s2_ff;
			// hold the last agreed level while stages differ
			if (res_agree)
				res_lvl_ff <= res_s3_ff;
		end
	end

	// ********************************
	// functional state next value
	// ********************************
	wire in_suspend = (state_ff == `FS_CODE_SUSPEND);
	// resume detection wakes suspend
	// a driver write in the same cycle beats the resume move
	assign nxt_state = soft_reset ? `FS_CODE_SUSPEND :
		ctrl_wr ? pwdata[`FS_MSB:`FS_LSB] :
		(in_suspend && resume_evt) ? `FS_CODE_RESUME : state_ff;

	// ********************************
	// other control fields
	// ********************************
	// driver writes only
	assign nxt_list_ctrl = soft_reset ? `RST_LIST_CTRL :
		ctrl_wr ? pwdata[`LIST_CTRL_MSB:0] : list_ctrl_ff;
	assign nxt_wake_en   = soft_reset ? 1'b0 :
		ctrl_wr ? pwdata[`WAKE_EN_BIT] : wake_en_ff;
	assign nxt_wake_conn = ctrl_wr ? pwdata[`WAKE_CONN_BIT] : wake_conn_ff;
	assign nxt_route     = ctrl_wr ? pwdata[`IRQ_ROUTE_BIT] : route_ff;

	// ********************************
	// frame start pacing
	// ********************************
	wire  operational = (state_ff == `FS_CODE_OPER); // bus running
	logic frame_pulse;                                // timer tick
	logic frame_start_ff;                             // registered tick

	frame_start_timer
	#(
		.PERIOD (SOF_DELAY_CYCLES)
	)
	u_frame_timer
	(
		.core_clk    (core_clk),
		.reset_n     (reset_n),
		.run         (operational),
		.frame_pulse (frame_pulse)
	);

	// ********************************
	// event flags and mask
	// ********************************
	event_bits_t flag_set; // hardware events this cycle
	event_bits_t flag_clr; // software clears this cycle
	assign flag_set = {resume_evt, frame_pulse, 2'b00};
	assign flag_clr = flags_wr ? pwdata[3:0] : `RST_FLAGS;
	// set wins over a clear or a soft reset in the same cycle, no event lost
	assign nxt_flags = (soft_reset ? `RST_FLAGS : (flags_ff & ~flag_clr)) | flag_set;
	assign nxt_mask  = mask_wr ? pwdata[3:0] : mask_ff;

	// ********************************
	// interrupt and wake outputs
	// ********************************
	// wake enable not in this term
	wire irq_any = |(flags_ff & mask_ff);
	logic irq_normal_ff; // host bus interrupt level
	logic irq_smi_ff;    // management interrupt level
	logic wake_ff;       // remote wake level
	logic port_rst_ff;   // downstream reset drive
	logic hub_rst_ff;    // root hub reset pulse

	// ********************************
	// register updates
	// ********************************
	// state, control word, flags and mask
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_ff     <= `FS_CODE_RESET;
			list_ctrl_ff <= `RST_LIST_CTRL;
			wake_en_ff   <= 1'b0;
			wake_conn_ff <= 1'b0;
			route_ff     <= 1'b0;
			flags_ff     <= `RST_FLAGS;
			mask_ff      <= `RST_MASK;
		end
		else
		begin
			state_ff     <= nxt_state;
			list_ctrl_ff <= nxt_list_ctrl;
			wake_en_ff   <= nxt_wake_en;
			wake_conn_ff <= nxt_wake_conn;
			route_ff     <= nxt_route;
			flags_ff     <= nxt_flags;
			mask_ff      <= nxt_mask;
		end
	end

	// output registers
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			frame_start_ff <= 1'b0;
			irq_normal_ff  <= 1'b0;
			irq_smi_ff     <= 1'b0;
			wake_ff        <= 1'b0;
			port_rst_ff    <= 1'b1;
			hub_rst_ff     <= 1'b1;
		end
		else
		begin
			frame_start_ff <= frame_pulse;
			irq_normal_ff  <= irq_any && !route_ff;
			irq_smi_ff     <= irq_any && route_ff;
			wake_ff        <= wake_en_ff && flags_ff[`FLAG_RESUME_BIT];
			port_rst_ff    <= (nxt_state == `FS_CODE_RESET);
			hub_rst_ff     <= 1'b0;
		end
	end

	assign frame_start      = frame_start_ff;
	assign irq_normal       = irq_normal_ff;
	assign irq_smi          = irq_smi_ff;
	assign remote_wake      = wake_ff;
	assign port_reset_drive = port_rst_ff;
	assign root_hub_reset   = hub_rst_ff;

	// ********************************
	// read data
	// ********************************
	apb_word_t rd_mux;  // selected word
	apb_word_t rdata_ff; // registered read data
	wire [`CTRL_USED_MSB:0] ctrl_word = {wake_en_ff, wake_conn_ff, route_ff, state_ff, list_ctrl_ff};
	assign rd_mux = hit_ctrl  ? {21'h00_0000, ctrl_word} :
		hit_flags ? {28'h000_0000, flags_ff} :
		hit_mask  ? {28'h000_0000, mask_ff} : 32'h0000_0000;

	// capture in the setup cycle, shown in the access cycle
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_ff <= 32'h0000_0000;
		else if (setup_rd)
			rdata_ff <= rd_mux;
	end
	assign prdata = rdata_ff;

	// ********************************
	// checks
	// ********************************
	logic [31:0] op_age_ff; // cycles since entering operational
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			op_age_ff <= 32'h0000_0000;
		else if (!operational)
			op_age_ff <= 32'h0000_0000;
		else if (op_age_ff != 32'hFFFF_FFFF)
			op_age_ff <= op_age_ff + 32'h0000_0001;
	end

	property p_state_read;
		setup_rd && hit_ctrl ##1 psel && penable |-> prdata[7:6] == $past(state_ff);
	endproperty
	a_state_read: assert property (p_state_read)
		else $error("state field read back wrong");

	property p_sof_delay;
		operational && op_age_ff == 32'(SOF_DELAY_CYCLES) |-> frame_start;
	endproperty
	a_sof_delay: assert property (p_sof_delay)
		else $error("frame start not 1 ms after entry");

	property p_sof_early;
		frame_start |-> op_age_ff >= 32'(SOF_DELAY_CYCLES);
	endproperty
	a_sof_early: assert property (p_sof_early)
		else $error("frame start came early");

	property p_sof_flag;
		frame_start && !soft_reset |-> flags_ff[`FLAG_FRAME_BIT];
	endproperty
	a_sof_flag: assert property (p_sof_flag)
		else $error("frame flag not set");

	property p_hw_move;
		!$past(ctrl_wr) && !$past(soft_reset) && state_ff != $past(state_ff)
			|-> $past(state_ff) == `FS_CODE_SUSPEND && state_ff == `FS_CODE_RESUME;
	endproperty
	a_hw_move: assert property (p_hw_move)
		else $error("state moved outside suspend");

	property p_resume;
		in_suspend && resume_evt && !ctrl_wr && !soft_reset |=> state_ff == `FS_CODE_RESUME;
	endproperty
	a_resume: assert property (p_resume)
		else $error("resume not taken");

	property p_wake;
		wake_en_ff && flags_ff[`FLAG_RESUME_BIT] |=> remote_wake;
	endproperty
	a_wake: assert property (p_wake)
		else $error("remote wake missing");

	property p_irq_indep;
		$changed(wake_en_ff) && $stable(flags_ff) && $stable(mask_ff) && $stable(route_ff)
			|=> $stable(irq_normal) && $stable(irq_smi);
	endproperty
	a_irq_indep: assert property (p_irq_indep)
		else $error("wake enable changed interrupt");

	property p_conn_keep;
		soft_reset |=> wake_conn_ff == $past(wake_conn_ff) && route_ff == $past(route_ff);
	endproperty
	a_conn_keep: assert property (p_conn_keep)
		else $error("soft reset altered kept bits");

	property p_route;
		(irq_smi |-> $past(route_ff)) and (irq_normal |-> !$past(route_ff));
	endproperty
	a_route: assert property (p_route)
		else $error("interrupt on wrong line");

	property p_fields;
		!ctrl_wr && !soft_reset |=> $stable(list_ctrl_ff) && $stable(wake_en_ff) && $stable(route_ff);
	endproperty
	a_fields: assert property (p_fields)
		else $error("control field changed by hardware");

	property p_soft;
		soft_reset |=> state_ff == `FS_CODE_SUSPEND ##1 !port_reset_drive;
	endproperty
	a_soft: assert property (p_soft)
		else $error("soft reset did not suspend");

	property p_upper;
		setup_rd && hit_ctrl |=> prdata[31:11] == 21'h00_0000;
	endproperty
	a_upper: assert property (p_upper)
		else $error("upper bits not zero");

	c_resume: cover property (in_suspend && resume_evt ##1 state_ff == `FS_CODE_RESUME);
	c_frame: cover property ($rose(frame_start));
	c_smi: cover property ($rose(irq_smi));
	c_wake: cover property ($rose(remote_wake));
endmodule : host_mode_control_bank

// ===== core/host_mode_control_params.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit APB data, byte addresses, one word per register
// Notes:   definitions only, no logic
`ifndef HOST_MODE_CONTROL_PARAMS_SVH
`define HOST_MODE_CONTROL_PARAMS_SVH

// ********************************
// register byte offsets
// ********************************
`define OFF_MODE_CONTROL   12'h004
`define OFF_RESET_COMMAND  12'h008
`define OFF_EVENT_FLAGS    12'h00C
`define OFF_EVENT_MASK     12'h010

// ********************************
// field positions
// ********************************
`define LIST_CTRL_MSB      5
`define FS_LSB             6
`define FS_MSB             7
`define IRQ_ROUTE_BIT      8
`define WAKE_CONN_BIT      9
`define WAKE_EN_BIT        10
`define CTRL_USED_MSB      10
`define FLAG_FRAME_BIT     2
`define FLAG_RESUME_BIT    3
`define CMD_SOFT_RESET_BIT 0

// ********************************
// functional state codes and resets
// ********************************
`define FS_CODE_RESET      2'h0
`define FS_CODE_RESUME     2'h1
`define FS_CODE_OPER       2'h2
`define FS_CODE_SUSPEND    2'h3
`define RST_LIST_CTRL      6'h00
`define RST_FLAGS          4'h0
`define RST_MASK           4'h0

// ********************************
// timing
// ********************************
`define CORE_CLK_PERIOD_NS 4
`define SOF_DELAY_NS       1000000
`define SOF_DELAY_CYCLES   (`SOF_DELAY_NS / `CORE_CLK_PERIOD_NS)

`endif

// ===== core/host_mode_control_pkg.sv
// Purpose: shared types of the mode control bank
// Assumes: constants live in host_mode_control_params.svh
// Notes:   types only
package host_mode_control_pkg;
	typedef logic [31:0] apb_word_t;   // bus data word
	typedef logic [11:0] apb_addr_t;   // decoded address bits
	typedef logic [1:0]  fs_code_t;    // functional state code
	typedef logic [3:0]  event_bits_t; // flag and mask layout
endpackage : host_mode_control_pkg

// ===== dv/downstream_port_model.sv
// Purpose: stand-in for the downstream ports behind the root hub
// Assumes: resume pin idles low between bursts of signalling
// Notes:   also counts frame starts that reach the ports
`timescale 1ns/1ps
module downstream_port_model
#(
	parameter int HOLD = 8
)
(
	input  wire logic core_clk,
	input  wire logic send_resume,
	input  wire logic frame_start,
	output logic      downstream_resume,
	output int        frame_count
);
	int left; // cycles of signalling still owed

	// ****************************************
	// resume burst, released low when it ends
	// ****************************************
	initial
	begin
		downstream_resume = 1'b0;
		left = 0;
		frame_count = 0;
	end

	// hold long enough for the three-stage synchroniser to agree
	always @(posedge core_clk)
	begin
		if (send_resume)
			left <= HOLD;
		else if (left > 0)
			left <= left - 1;
		downstream_resume <= send_resume || left > 1;
		if (frame_start)
			frame_count <= frame_count + 1;
	end
endmodule : downstream_port_model

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the mode control bank
// Assumes: zero wait state slave, frame delay shortened to SOF cycles
// Notes:   read results are checked from a queue of notes
`timescale 1ns/1ps
`include "host_mode_control_params.svh"
module tb_top;
	import host_mode_control_pkg::*;
	localparam int SOF = 20; // short frame delay keeps the run brief
	typedef struct {apb_word_t d; logic e;} note_t;
	logic      core_clk, reset_n, psel, penable, pwrite, send_resume;
	apb_addr_t paddr;
	apb_word_t pwdata, prdata, seed;
	logic      pready, pslverr, downstream_resume, frame_start, remote_wake;
	logic      irq_normal, irq_smi, port_reset_drive, root_hub_reset;
	int        bad_count, samples_checked, cyc, last_fs, gap, arm, frames, f0;
	note_t     notes[$]; // expected read results, oldest first
	note_t     n;

	host_mode_control_bank #(.SOF_DELAY_CYCLES(SOF)) DUT (.core_clk(core_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .downstream_resume(downstream_resume),
		.frame_start(frame_start), .remote_wake(remote_wake), .irq_normal(irq_normal),
		.irq_smi(irq_smi), .port_reset_drive(port_reset_drive), .root_hub_reset(root_hub_reset));
	downstream_port_model ports (.core_clk(core_clk), .send_resume(send_resume),
		.frame_start(frame_start), .downstream_resume(downstream_resume), .frame_count(frames));

	// ****************************************
	// clock and helpers
	// ****************************************
	always #2 core_clk = ~core_clk;

	function automatic apb_word_t lfsr(input apb_word_t s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test();
		$display("checks made %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test

	// one apb transfer; waits for pready, then one idle edge
	task automatic bus(input logic w, input apb_addr_t a, input apb_word_t d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never completes
		do
		begin
			@(posedge core_clk);
		end
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : bus

	task automatic rd(input apb_addr_t a, input apb_word_t d, input logic e);
		notes.push_back('{d, e});
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd

	// resume burst then time for sync, flag and wake to settle
	task automatic pulse_resume();
		send_resume <= 1'b1;
		@(posedge core_clk);
		send_resume <= 1'b0;
		repeat (12) @(posedge core_clk);
	endtask : pulse_resume

	// ****************************************
	// monitor: reads against notes, frame spacing
	// ****************************************
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (psel && penable && pready && !pwrite && notes.size() > 0)
		begin
			n = notes.pop_front();
			check(prdata, n.d);
			check(32'(pslverr), 32'(n.e));
		end
		// first frame is seen one edge after it is launched
		if (psel && penable && pwrite && paddr == `OFF_MODE_CONTROL && pwdata[7:6] == `FS_CODE_OPER)
		begin
			arm <= 2;
			gap <= SOF + 1;
			last_fs <= cyc;
		end
		else if (frame_start && arm > 0)
		begin
			check(32'(cyc - last_fs), 32'(gap));
			arm <= arm - 1;
			gap <= SOF;
			last_fs <= cyc;
		end
	end

	// ****************************************
	// watchdog
	// ****************************************
	initial
	begin
		#80000;
		bad_count++;
		finish_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		core_clk = 0; reset_n = 0; psel = 0; penable = 0; pwrite = 0; send_resume = 0;
		paddr = '0; pwdata = '0; seed = 32'hb2ed_e57d; cyc = 0; arm = 0; gap = 0; last_fs = 0;
		bad_count = 0; samples_checked = 0;
		repeat (16) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		check(port_reset_drive, 1);
		check(root_hub_reset, 0);
		rd(`OFF_MODE_CONTROL, 32'h0000_0000, 0);
		// reserved upper bits refuse writes, low bits store
		for (int i = 0; i < 3; i++)
		begin
			seed = lfsr(seed);
			bus(1, `OFF_MODE_CONTROL, 32'hFFFF_F800 | seed[5:0]);
			rd(`OFF_MODE_CONTROL, {26'h0, seed[5:0]}, 0);
		end
		bus(1, `OFF_MODE_CONTROL, 32'h0000_0200);
		bus(1, `OFF_MODE_CONTROL, 32'h0000_0280);
		repeat (3 * SOF) @(posedge core_clk);
		rd(`OFF_EVENT_FLAGS, 32'h0000_0004, 0);
		check(port_reset_drive, 0);
		// resume while operational must not move the state
		pulse_resume();
		rd(`OFF_MODE_CONTROL, 32'h0000_0280, 0);
		rd(`OFF_EVENT_FLAGS, 32'h0000_000C, 0);
		bus(1, `OFF_MODE_CONTROL, 32'h0000_02C0);
		repeat (2) @(posedge core_clk);
		f0 = frames;
		repeat (3 * SOF) @(posedge core_clk);
		check(32'(frames), 32'(f0));
		bus(1, `OFF_EVENT_FLAGS, 32'h0000_000F);
		rd(`OFF_EVENT_FLAGS, 32'h0000_0000, 0);
		bus(1, `OFF_EVENT_MASK, 32'h0000_0008);
		check(irq_normal, 0);
		// suspend with wake enabled, then downstream resume
		bus(1, `OFF_MODE_CONTROL, 32'h0000_06C0);
		pulse_resume();
		rd(`OFF_MODE_CONTROL, 32'h0000_0640, 0);
		check(remote_wake, 1);
		check(irq_normal, 1);
		check(irq_smi, 0);
		bus(1, `OFF_MODE_CONTROL, 32'h0000_0240);
		repeat (3) @(posedge core_clk);
		check(remote_wake, 0);
		check(irq_normal, 1);
		bus(1, `OFF_MODE_CONTROL, 32'h0000_0340);
		repeat (3) @(posedge core_clk);
		check(irq_smi, 1);
		check(irq_normal, 0);
		bus(1, `OFF_EVENT_MASK, 32'h0000_0000);
		repeat (3) @(posedge core_clk);
		check(irq_smi, 0);
		for (int i = 0; i < 3; i++)
		begin
			seed = lfsr(seed);
			bus(1, `OFF_EVENT_MASK, seed);
			rd(`OFF_EVENT_MASK, seed & 32'h0000_000F, 0);
		end
		rd(12'h7F0, 32'h0000_0000, 1);
		// software reset keeps connected and routing bits
		bus(1, `OFF_RESET_COMMAND, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		rd(`OFF_MODE_CONTROL, 32'h0000_03C0, 0);
		rd(`OFF_EVENT_FLAGS, 32'h0000_0000, 0);
		// hardware reset clears the registers and raises both reset outputs
		reset_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		check(root_hub_reset, 1);
		check(port_reset_drive, 1);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rd(`OFF_MODE_CONTROL, 32'h0000_0000, 0);
		finish_test();
	end
endmodule : tb_top
